// ### design/supervisor_port_cfg.svh
// Constants of the supervisory port: address, bit positions, reset and watchdog timing.
// Assumes a 50 MHz system clock and an ISA-style 10-bit I/O address.
`ifndef SUPERVISOR_PORT_CFG_SVH
`define SUPERVISOR_PORT_CFG_SVH

`define SUP_PORT_ADDR        10'h201
`define SUP_PORT_RESET       8'h00
`define SUP_BIT_WDG_EN       0
`define SUP_BIT_WDG_REFRESH  1
`define SUP_BIT_VPP_SEL      2
`define SUP_BIT_RS485_DIR    3
`define SUP_BIT_PRN_DIR      4
`define SUP_BIT_ALT_BANK     5
`define SUP_CLK_HZ           50000000
`define SUP_WDG_TIMEOUT_MS   1600
`define SUP_WDG_TIMEOUT_CYC  ((`SUP_CLK_HZ / 1000) * `SUP_WDG_TIMEOUT_MS)
`define SUP_RST_PULSE_CYC    64

`endif

// ### design/supervisor_port_pkg.sv
// Types shared by the supervisory port design.
// Assumes the constants header is compiled alongside.
package supervisor_port_pkg;
    typedef logic [7:0] port_byte_t;
    typedef enum logic [2:0] {
        WDG_OFF   = 3'b001,
        WDG_RUN   = 3'b010,
        WDG_RESET = 3'b100
    } wdg_state_t;
endpackage

// ### design/watchdog_core.sv
// Watchdog timer core: timeout counter and reset pulse generator.
// Assumes enable and refresh come from same-clock registers.
`timescale 1ns/1ps
`include "supervisor_port_cfg.svh"
module watchdog_core #(
    parameter int TIMEOUT_CYC = `SUP_WDG_TIMEOUT_CYC,
    parameter int PULSE_CYC   = `SUP_RST_PULSE_CYC
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic wdg_active,
    input  wire logic refresh_bit,
    output logic      wdg_reset
);
    import supervisor_port_pkg::*;

    wdg_state_t  state_r, state_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic        last_ref_r, last_ref_nxt;

    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        last_ref_nxt = refresh_bit;
        unique case (state_r)
            WDG_OFF: begin
                cnt_nxt = '0;
                if (wdg_active) begin
                    state_nxt = WDG_RUN;
                end
            end
            WDG_RUN: begin
                if (!wdg_active) begin
                    state_nxt = WDG_OFF;
                    cnt_nxt   = '0;
                end else if (refresh_bit != last_ref_r) begin
                    cnt_nxt = '0;
                end else if (cnt_r >= 32'(TIMEOUT_CYC - 1)) begin
                    state_nxt = WDG_RESET;
                    cnt_nxt   = '0;
                end else begin
                    cnt_nxt = cnt_r + 32'd1;
                end
            end
            WDG_RESET: begin
                if (cnt_r >= 32'(PULSE_CYC - 1)) begin
                    state_nxt = WDG_OFF;
                    cnt_nxt   = '0;
                end else begin
                    cnt_nxt = cnt_r + 32'd1;
                end
            end
            default: begin
                state_nxt = WDG_OFF;
                cnt_nxt   = '0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r    <= WDG_OFF;
            cnt_r      <= '0;
            last_ref_r <= 1'b0;
        end else if (clk_en) begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            last_ref_r <= last_ref_nxt;
        end
    end

    assign wdg_reset = (state_r == WDG_RESET);
endmodule // watchdog_core

// ### design/supervisor_port.sv
// Supervisory I/O port: watchdog, programming voltage, RS-485 and printer direction,
// power-fail status and NMI routing, one byte at a fixed I/O address.
// Assumes a synchronous I/O strobe interface from bus logic on clk; straps and the
// detector pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
`include "supervisor_port_cfg.svh"
module supervisor_port #(
    parameter int TIMEOUT_CYC = `SUP_WDG_TIMEOUT_CYC,
    parameter int PULSE_CYC   = `SUP_RST_PULSE_CYC
) (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      clk_en,
    input  wire logic [9:0]                io_addr,
    input  wire logic                      io_wr,
    input  wire logic                      io_rd,
    input  wire supervisor_port_pkg::port_byte_t io_wdata,
    output supervisor_port_pkg::port_byte_t      io_rdata,
    output logic                           io_sel,
    input  wire logic                      watchdog_permit_strap,
    input  wire logic                      nmi_disable_strap,
    input  wire logic                      detect_source_strap,
    input  wire logic                      supply_detect_n,
    input  wire logic                      battery_detect_n,
    input  wire logic                      alternate_switch_bank,
    input  wire logic                      uart_rts,
    output logic                           iocheck_n,
    output logic                           rs485_tx_en,
    output logic                           vpp_12v_sel,
    output logic                           printer_data_in,
    output logic                           wdg_reset
);
    import supervisor_port_pkg::*;

    // Two-stage synchronisers for the asynchronous pins, one generate entry per pin except the NMI strap, which has its own pair below.
    localparam int NSYNC = 6;
    // The detector pins idle high, so their stages reset to one; a reset to zero would
    // report a false power fail and pull the NMI line for two cycles after every reset.
    localparam logic [NSYNC-1:0] SYNC_IDLE = 6'h0C;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1_r, sync1_nxt;
    logic [NSYNC-1:0] sync2_r, sync2_nxt;
    assign async_in = {uart_rts, alternate_switch_bank, battery_detect_n,
                       supply_detect_n, detect_source_strap, watchdog_permit_strap};
    logic nmi_dis_s1_r, nmi_dis_s2_r;

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_comb begin
                sync1_nxt[gi] = async_in[gi];
                sync2_nxt[gi] = sync1_r[gi];
            end
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    sync1_r[gi] <= SYNC_IDLE[gi];
                    sync2_r[gi] <= SYNC_IDLE[gi];
                end else if (clk_en) begin
                    sync1_r[gi] <= sync1_nxt[gi];
                    sync2_r[gi] <= sync2_nxt[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            nmi_dis_s1_r <= 1'b0;
            nmi_dis_s2_r <= 1'b0;
        end else if (clk_en) begin
            nmi_dis_s1_r <= nmi_disable_strap;
            nmi_dis_s2_r <= nmi_dis_s1_r;
        end
    end

    logic permit_s, src_s, supply_s, battery_s, alt_bank_s, rts_s;
    assign permit_s   = sync2_r[0];
    assign src_s      = sync2_r[1];
    assign supply_s   = sync2_r[2];
    assign battery_s  = sync2_r[3];
    assign alt_bank_s = sync2_r[4];
    assign rts_s      = sync2_r[5];

    // Port register state.
    logic wdg_en_r, wdg_en_nxt;
    logic refresh_r, refresh_nxt;
    logic vpp_r, vpp_nxt;
    logic rs485_en_r, rs485_en_nxt;
    logic prn_dir_r, prn_dir_nxt;
    port_byte_t rdata_r, rdata_nxt;
    logic hit;
    logic power_fail_output;

    assign hit    = (io_addr == `SUP_PORT_ADDR);
    assign io_sel = hit & (io_rd | io_wr);

    // One comparator serves both supply and battery, so only one source is watched.
    assign power_fail_output = src_s ? battery_s : supply_s;

    always_comb begin
        wdg_en_nxt   = wdg_en_r;
        refresh_nxt  = refresh_r;
        vpp_nxt      = vpp_r;
        rs485_en_nxt = rs485_en_r;
        prn_dir_nxt  = prn_dir_r;
        rdata_nxt    = rdata_r;
        if (hit && io_wr) begin
            wdg_en_nxt   = io_wdata[`SUP_BIT_WDG_EN];
            refresh_nxt  = io_wdata[`SUP_BIT_WDG_REFRESH];
            vpp_nxt      = io_wdata[`SUP_BIT_VPP_SEL];
            rs485_en_nxt = io_wdata[`SUP_BIT_RS485_DIR];
            prn_dir_nxt  = io_wdata[`SUP_BIT_PRN_DIR];
        end
        // A watchdog reset restarts the whole board, so the five control bits clear with it; rdata_r keeps its value.
        if (wdg_reset) begin
            wdg_en_nxt   = 1'b0;
            refresh_nxt  = 1'b0;
            vpp_nxt      = 1'b0;
            rs485_en_nxt = 1'b0;
            prn_dir_nxt  = 1'b0;
        end
        if (hit && io_rd) begin
            rdata_nxt = 8'h00;
            rdata_nxt[`SUP_BIT_WDG_EN]      = wdg_en_r;
            rdata_nxt[`SUP_BIT_WDG_REFRESH] = refresh_r;
            rdata_nxt[`SUP_BIT_VPP_SEL]     = vpp_r;
            // Status is read regardless of the NMI strap; zero means failure.
            rdata_nxt[`SUP_BIT_RS485_DIR]   = power_fail_output;
            rdata_nxt[`SUP_BIT_ALT_BANK]    = alt_bank_s;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wdg_en_r   <= 1'b0;
            refresh_r  <= 1'b0;
            vpp_r      <= 1'b0;
            rs485_en_r <= 1'b0;
            prn_dir_r  <= 1'b0;
            rdata_r    <= `SUP_PORT_RESET;
        end else if (clk_en) begin
            wdg_en_r   <= wdg_en_nxt;
            refresh_r  <= refresh_nxt;
            vpp_r      <= vpp_nxt;
            rs485_en_r <= rs485_en_nxt;
            prn_dir_r  <= prn_dir_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    // Outputs other than io_sel, which is decoded directly from the bus inputs, are driven from registers or from registered pins only.
    logic iocheck_n_r, rs485_tx_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            iocheck_n_r <= 1'b1;
            rs485_tx_r  <= 1'b0;
        end else if (clk_en) begin
            iocheck_n_r <= power_fail_output | nmi_dis_s2_r;
            rs485_tx_r  <= rs485_en_r & rts_s;
        end
    end

    assign io_rdata        = rdata_r;
    assign iocheck_n       = iocheck_n_r;
    assign rs485_tx_en     = rs485_tx_r;
    assign vpp_12v_sel     = vpp_r;
    assign printer_data_in = prn_dir_r;

    watchdog_core #(
        .TIMEOUT_CYC (TIMEOUT_CYC),
        .PULSE_CYC   (PULSE_CYC)
    ) u_wdg (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .clk_en      (clk_en),
        .wdg_active  (wdg_en_r & permit_s),
        .refresh_bit (refresh_r),
        .wdg_reset   (wdg_reset)
    );
endmodule // supervisor_port

// ### test/supervisor_port_checker.sv
// Concurrent checks on the supervisory port pins, bound to its top module.
// Assumes clk_en is held high by the bench.
`timescale 1ns/1ps
module supervisor_port_checker #(
    parameter int PULSE_CYC = 4
) (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [9:0] io_addr,
    input wire logic       io_wr,
    input wire logic [7:0] io_wdata,
    input wire logic       watchdog_permit_strap,
    input wire logic       uart_rts,
    input wire logic       rs485_tx_en,
    input wire logic       vpp_12v_sel,
    input wire logic       printer_data_in,
    input wire logic       wdg_reset
);
    logic [7:0] hi_cnt_r;
    logic [7:0] hi_cnt_nxt;
    // A counter keeps the pulse length check free of long repetitions.
    always_comb hi_cnt_nxt = wdg_reset ? hi_cnt_r + 8'h01 : 8'h00;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) hi_cnt_r <= 8'h00;
        else hi_cnt_r <= hi_cnt_nxt;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_wr;
        io_wr && io_addr == 10'h201;
    endsequence
    a_vpp_write: assert property (s_wr ##0 io_wdata[2] ##0 !wdg_reset |=> vpp_12v_sel)
        else $error("vpp not set");
    a_prn_write: assert property (s_wr ##0 !io_wdata[4] |=> !printer_data_in)
        else $error("printer dir not cleared");
    a_rs485_off: assert property (s_wr ##0 !io_wdata[3] |-> ##2 !rs485_tx_en)
        else $error("rs485 stays on");
    a_rs485_rts: assert property (!uart_rts [*5] |-> !rs485_tx_en)
        else $error("rs485 on without rts");
    a_pulse_len: assert property ($fell(wdg_reset) |-> hi_cnt_r == 8'(PULSE_CYC))
        else $error("pulse length wrong");
    a_pulse_clear: assert property ($rose(wdg_reset) |-> ##1 !vpp_12v_sel && !printer_data_in)
        else $error("bits not cleared by pulse");
    a_permit_gate: assert property ($rose(wdg_reset) |-> $past(watchdog_permit_strap, 4))
        else $error("pulse without permit");
    a_reset_clear: assert property ($fell(sys_rst) |-> !wdg_reset && !vpp_12v_sel)
        else $error("outputs not clear after reset");
endmodule // supervisor_port_checker

bind supervisor_port supervisor_port_checker #(.PULSE_CYC(PULSE_CYC)) i_chk (
    .clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata),
    .watchdog_permit_strap(watchdog_permit_strap), .uart_rts(uart_rts), .wdg_reset(wdg_reset),
    .rs485_tx_en(rs485_tx_en), .vpp_12v_sel(vpp_12v_sel), .printer_data_in(printer_data_in));

// ### test/host_bus_model.sv
// Host processor model: single-byte I/O writes and reads with one-cycle strobes.
// Assumes the port takes a strobe on the rising clock edge.
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic                           clk,
    input  wire supervisor_port_pkg::port_byte_t io_rdata,
    output logic [9:0]                          io_addr,
    output logic                                io_wr,
    output logic                                io_rd,
    output supervisor_port_pkg::port_byte_t     io_wdata
);
    import supervisor_port_pkg::*;
    initial {io_addr, io_wr, io_rd, io_wdata} = '0;
    // Released data shows the inverse, so a stale byte is never taken for fresh.
    task automatic wr(input logic [9:0] a, input port_byte_t v);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= v;
        io_wr    <= 1'b1;
        @(posedge clk);
        io_wr    <= 1'b0;
        io_wdata <= ~v;
    endtask
    task automatic rd(input logic [9:0] a, output port_byte_t v);
        @(posedge clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge clk);
        io_rd   <= 1'b0;
        @(negedge clk);
        v = io_rdata;
    endtask
endmodule // host_bus_model

// ### test/supervisor_port_watchdog_pfd_tb.sv
// Bench of the supervisory port driven through the host bus model.
// Assumes a 100-cycle watchdog timeout and a 4-cycle reset pulse.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", what, exp, got); end end
module supervisor_port_watchdog_pfd_tb;
    import supervisor_port_pkg::*;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic [6:0] pins = 7'b0000011;
    logic [9:0] io_addr;
    logic       io_wr, io_rd, iocheck_n, rs485_tx_en, vpp_12v_sel, printer_data_in, wdg_reset;
    port_byte_t io_wdata, io_rdata, d;
    int         mismatches = 0, n_compared = 0, pulses = 0;
    initial forever #10 clk = ~clk;
    always @(posedge wdg_reset) pulses++;
    supervisor_port #(.TIMEOUT_CYC(100), .PULSE_CYC(4)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_sel(),
        .alternate_switch_bank(pins[6]), .uart_rts(pins[5]), .watchdog_permit_strap(pins[4]),
        .nmi_disable_strap(pins[3]), .detect_source_strap(pins[2]), .battery_detect_n(pins[1]),
        .supply_detect_n(pins[0]), .iocheck_n(iocheck_n), .rs485_tx_en(rs485_tx_en),
        .vpp_12v_sel(vpp_12v_sel), .printer_data_in(printer_data_in), .wdg_reset(wdg_reset));
    host_bus_model i_host (.clk(clk), .io_rdata(io_rdata), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata));
    task automatic finish_test();
        if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic rd_chk(input port_byte_t e);
        i_host.rd(10'h201, d);
        `CHK("port", e, d)
    endtask
    // Pins are synchronised inside, so each change is given time to settle.
    task automatic set_pins(input logic [6:0] v);
        @(posedge clk);
        pins <= v;
        repeat (8) @(posedge clk);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd_chk(8'h08);
        `CHK("nmi", 1'b1, iocheck_n)
        i_host.wr(10'h201, 8'hFF);
        rd_chk(8'h0F);
        `CHK("vpp", 1'b1, vpp_12v_sel)
        `CHK("prn", 1'b1, printer_data_in)
        set_pins(7'b0100011);
        `CHK("rs485", 1'b1, rs485_tx_en)
        repeat (200) @(posedge clk);
        `CHK("pulses", 0, pulses)
        i_host.wr(10'h200, 8'h00);
        i_host.rd(10'h200, d);
        `CHK("unmapped", 8'h0F, d)
        i_host.wr(10'h201, 8'h00);
        set_pins(7'b1100010);
        `CHK("rs485", 1'b0, rs485_tx_en)
        `CHK("prn", 1'b0, printer_data_in)
        rd_chk(8'h20);
        `CHK("nmi", 1'b0, iocheck_n)
        set_pins(7'b1101010);
        `CHK("nmi", 1'b1, iocheck_n)
        rd_chk(8'h20);
        set_pins(7'b1100110);
        rd_chk(8'h28);
        set_pins(7'b1100100);
        `CHK("nmi", 1'b0, iocheck_n)
        set_pins(7'b0010110);
        i_host.wr(10'h201, 8'h01);
        for (int i = 0; i < 6; i++) begin
            repeat (60) @(posedge clk);
            i_host.wr(10'h201, i[0] ? 8'h01 : 8'h03);
        end
        `CHK("pulses", 0, pulses)
        repeat (150) @(posedge clk);
        `CHK("pulses", 1, pulses)
        rd_chk(8'h08);
        repeat (200) @(posedge clk);
        `CHK("pulses", 1, pulses)
        finish_test();
    end
    initial begin
        #400000;
        mismatches++;
        finish_test();
    end
endmodule // supervisor_port_watchdog_pfd_tb
